// ### logic/fsps_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit wishbone slave decoding word-aligned byte addresses
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH

// byte offsets of the slave registers
`define FSPS_OFS_CTRL      8'h00
`define FSPS_OFS_KEY       8'h04
`define FSPS_OFS_PAGE      8'h08
`define FSPS_OFS_EA        8'h0c
`define FSPS_OFS_TBL_LOW   8'h10
`define FSPS_OFS_TBL_HIGH  8'h14

// control register field positions
`define FSPS_BIT_WR        15
`define FSPS_BIT_WRITE_ENABLE_BIT      14
`define FSPS_BIT_ERR       13
`define FSPS_BIT_ERASE     6
`define FSPS_CTRL_RESET    16'h0000

// unlock key values
`define FSPS_KEY_FIRST     8'h55
`define FSPS_KEY_SECOND    8'haa

// operation codes
`define FSPS_OP_ROW        4'h1
`define FSPS_OP_BLOCK      4'h2
`define FSPS_OP_WORD       4'h3
`define FSPS_OP_BULK       4'hf

// array geometry in instructions
`define FSPS_ROW_WORDS     64
`define FSPS_BLOCK_WORDS   512
`define FSPS_ERASED_WORD   24'hffffff

// self-timed settle time and its cycle count at the clock rate
`define FSPS_CLK_MHZ       125
`define FSPS_OP_TIME_NS    2000
`define FSPS_OP_CYC        ((`FSPS_OP_TIME_NS * `FSPS_CLK_MHZ + 999) / 1000)

`endif

// ### logic/fsps_pkg.sv
// types shared by the flash self-program sequencer
// assumes the offsets and counts of fsps_regs.svh
package fsps_pkg;

  // sequencer phases
  typedef enum logic [1:0] {
    FSPS_IDLE   = 2'b00,
    FSPS_RUN    = 2'b01,
    FSPS_SETTLE = 2'b10
  } fsps_phase_t;

  // unlock progress
  typedef enum logic [1:0] {
    FSPS_KEY_NONE  = 2'b00,
    FSPS_KEY_HALF  = 2'b01,
    FSPS_KEY_ARMED = 2'b10
  } fsps_key_t;

  // kind of running operation
  typedef enum logic [1:0] {
    FSPS_K_WORD  = 2'b00,
    FSPS_K_ROW   = 2'b01,
    FSPS_K_BLOCK = 2'b10,
    FSPS_K_BULK  = 2'b11
  } fsps_kind_t;

  // control register contents
  typedef struct packed {
    logic       wr;
    logic       write_enable_bit;
    logic       err;
    logic       erase;
    logic [3:0] op;
  } fsps_ctrl_t;

endpackage

// ### logic/fsps_top.sv
// flash self-program sequencer: table access, holding latches, unlock, timed ops
// assumes a classic wishbone master on clk and a cpu that waits on stall
//
// Operation
// RQ1 - target address is page over effective address
// RQ2 - low table access covers bits 15..0
// RQ3 - high table access covers bits 23..16
// RQ4 - rows hold 64 instructions, row programmed
// RQ5 - erase eight rows, program row or word
// RQ6 - blocks and rows aligned from array start
// RQ7 - table writes fill latches, never array
// RQ8 - row program works after any latch count
// RQ9 - software fills unused latches with ones
// RQ10 - latches load any order, last wins
// RQ11 - table write is one latch write
// RQ12 - key 55h then AAh before start
// RQ13 - cpu stalled while operation runs
// RQ14 - start bit settable, cleared on completion
// RQ15 - enable bit gates program and erase
// RQ16 - error flag on bad start or termination
// RQ17 - erase select picks erase or program
// RQ18 - operation code decode with select match
// RQ19 - bulk erase only in serial mode
// RQ20 - control bits clear only on power-on
// RQ21 - configuration space is read-only
// RQ22 - start without key or enable errors
// RQ23 - unimplemented control bits read zero
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`include "fsps_regs.svh"

module fsps_top #(
  parameter int ARRAY_WORDS = 2048  // instructions in the array
) (
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        srst,
  // warm reset: aborts an operation, clears start, flags error if one was running, keeps the other control bits
  input  wire logic        warm_rst,
  // external serial programming mode pin
  input  wire logic        ext_prog_mode,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // processor stall while an operation runs
  output logic             stall
);

  localparam int AW = $clog2(ARRAY_WORDS);  // array index width

  // geometry the sequencer can serve
  if (ARRAY_WORDS % `FSPS_BLOCK_WORDS != 0 || ARRAY_WORDS < `FSPS_BLOCK_WORDS) begin : g_chk
    $error("ARRAY_WORDS must be a whole number of erase blocks");
  end

  // all control state
  typedef struct packed {
    fsps_pkg::fsps_ctrl_t  ctrl;
    logic [7:0]            page;
    logic [15:0]           ea;
    logic [23:0]           tgt;
    fsps_pkg::fsps_key_t   key;
    fsps_pkg::fsps_phase_t ph;
    fsps_pkg::fsps_kind_t  kind;
    logic [AW:0]           cnt;
    logic [AW:0]           last;
    logic [7:0]            tmr;
    logic                  ack;
    logic [31:0]           dat;
    logic                  ext_m;
    logic                  ext_s;
  } fsps_state_t;

  fsps_state_t s_q;  // registered state
  fsps_state_t s_d;  // next state

  // array and holding latches; flash data has no reset
  logic [23:0] mem_q [ARRAY_WORDS];
  logic [23:0] lat_q [`FSPS_ROW_WORDS];

  // array and latch write ports, filled below
  logic          mem_we;
  logic [AW-1:0] mem_idx;
  logic [23:0]   mem_dat;
  logic          lat_we;
  logic [5:0]    lat_idx;
  logic [23:0]   lat_mask;
  logic [23:0]   lat_dat;

  // decode of the current bus request
  logic          req;
  logic          wr_req;
  logic          rd_req;
  logic [23:0]   acc_adr;
  logic [AW-1:0] acc_idx;
  logic          word_mode;
  logic          cfg_sp;
  logic [23:0]   rd_word;
  logic          start_try;
  logic          op_ok;
  logic          start_ok;
  logic          sel_row;
  logic          sel_word;
  logic          sel_block;
  logic          sel_bulk;
  logic [AW-1:0] run_idx;

  // new request only when idle and not already answered
  assign req    = cyc_i && stb_i && !s_q.ack && (s_q.ph == fsps_pkg::FSPS_IDLE);
  assign wr_req = req && we_i;
  assign rd_req = req && !we_i;

  // RQ1 page over effective address
  assign acc_adr   = {s_q.page, s_q.ea};
  // two byte addresses per instruction
  assign acc_idx   = acc_adr[AW:1];
  assign word_mode = sel_i[1];
  // RQ21 page msb selects configuration space
  assign cfg_sp    = s_q.page[7];
  assign rd_word   = cfg_sp ? 24'h000000 : mem_q[acc_idx];

  // RQ18 opcode must match erase select
  assign sel_row   = !dat_i[`FSPS_BIT_ERASE] && dat_i[3:0] == `FSPS_OP_ROW;
  assign sel_word  = !dat_i[`FSPS_BIT_ERASE] && dat_i[3:0] == `FSPS_OP_WORD;
  assign sel_block = dat_i[`FSPS_BIT_ERASE] && dat_i[3:0] == `FSPS_OP_BLOCK;
  // RQ19 bulk erase only in serial mode
  assign sel_bulk  = dat_i[`FSPS_BIT_ERASE] && dat_i[3:0] == `FSPS_OP_BULK && s_q.ext_s;
  assign op_ok     = sel_row || sel_word || sel_block || sel_bulk;

  // RQ14 writing one to start is an attempt
  assign start_try = wr_req && adr_i == `FSPS_OFS_CTRL && sel_i[1] && dat_i[`FSPS_BIT_WR];
  // RQ12 RQ15 RQ22 key armed and enabled
  assign start_ok  = start_try && s_q.key == fsps_pkg::FSPS_KEY_ARMED
                     && dat_i[`FSPS_BIT_WRITE_ENABLE_BIT] && op_ok;

  // RQ6 aligned bases from array start
  assign run_idx   = s_q.tgt[AW:1];

  // next-state logic
  always_comb begin
    s_d      = s_q;
    mem_we   = 1'b0;
    mem_idx  = '0;
    mem_dat  = `FSPS_ERASED_WORD;
    lat_we   = 1'b0;
    lat_idx  = acc_idx[5:0];
    lat_mask = 24'h000000;
    lat_dat  = {dat_i[7:0], dat_i[15:0]};
    // pin passes two flops before use
    s_d.ext_m = ext_prog_mode;
    s_d.ext_s = s_q.ext_m;
    // wishbone answer lasts one cycle
    s_d.ack   = req;
    if (rd_req) begin
      // unmapped and write-only addresses read zero
      s_d.dat = 32'h00000000;
      case (adr_i)
        // RQ23 unimplemented bits read zero
        `FSPS_OFS_CTRL: s_d.dat = {16'h0000, s_q.ctrl.wr, s_q.ctrl.write_enable_bit, s_q.ctrl.err,
                                   6'h00, s_q.ctrl.erase, 2'h0, s_q.ctrl.op};
        `FSPS_OFS_PAGE: s_d.dat = {24'h000000, s_q.page};
        `FSPS_OFS_EA:   s_d.dat = {16'h0000, s_q.ea};
        // RQ2 low word, byte mode picks by address bit
        `FSPS_OFS_TBL_LOW: begin
          if (word_mode) begin
            s_d.dat = {16'h0000, rd_word[15:0]};
          end else begin
            s_d.dat = {24'h000000, s_q.ea[0] ? rd_word[15:8] : rd_word[7:0]};
          end
        end
        // RQ3 high byte, phantom byte reads zero
        `FSPS_OFS_TBL_HIGH: begin
          s_d.dat = {24'h000000, (word_mode || !s_q.ea[0]) ? rd_word[23:16] : 8'h00};
        end
        default: s_d.dat = 32'h00000000;
      endcase
    end
    if (wr_req) begin
      // RQ12 any other write breaks the key sequence
      s_d.key = fsps_pkg::FSPS_KEY_NONE;
      case (adr_i)
        `FSPS_OFS_CTRL: begin
          if (sel_i[0]) begin
            s_d.ctrl.erase = dat_i[`FSPS_BIT_ERASE];
            s_d.ctrl.op    = dat_i[3:0];
          end
          if (sel_i[1]) begin
            s_d.ctrl.write_enable_bit = dat_i[`FSPS_BIT_WRITE_ENABLE_BIT];
            s_d.ctrl.err  = dat_i[`FSPS_BIT_ERR];
            // RQ22 RQ16 improper start sets error
            if (start_try && !start_ok) begin
              s_d.ctrl.err = 1'b1;
            end
            // RQ13 RQ14 valid start launches operation
            if (start_ok) begin
              s_d.ctrl.wr = 1'b1;
              s_d.ph      = fsps_pkg::FSPS_RUN;
              s_d.cnt     = '0;
              // RQ17 RQ5 pick operation and extent
              if (sel_word) begin
                s_d.kind = fsps_pkg::FSPS_K_WORD;
                s_d.last = '0;
              end else if (sel_row) begin
                s_d.kind = fsps_pkg::FSPS_K_ROW;
                s_d.last = (AW+1)'(`FSPS_ROW_WORDS - 1);
              end else if (sel_block) begin
                s_d.kind = fsps_pkg::FSPS_K_BLOCK;
                s_d.last = (AW+1)'(`FSPS_BLOCK_WORDS - 1);
              end else begin
                s_d.kind = fsps_pkg::FSPS_K_BULK;
                s_d.last = (AW+1)'(ARRAY_WORDS - 1);
              end
            end
          end
        end
        // RQ12 55h then AAh on consecutive writes
        `FSPS_OFS_KEY: begin
          if (dat_i[7:0] == `FSPS_KEY_FIRST) begin
            s_d.key = fsps_pkg::FSPS_KEY_HALF;
          end else if (dat_i[7:0] == `FSPS_KEY_SECOND && s_q.key == fsps_pkg::FSPS_KEY_HALF) begin
            s_d.key = fsps_pkg::FSPS_KEY_ARMED;
          end
        end
        `FSPS_OFS_PAGE: begin
          if (sel_i[0]) s_d.page = dat_i[7:0];
        end
        `FSPS_OFS_EA: begin
          if (sel_i[0]) s_d.ea[7:0]  = dat_i[7:0];
          if (sel_i[1]) s_d.ea[15:8] = dat_i[15:8];
        end
        // RQ7 RQ11 table write loads one latch only
        `FSPS_OFS_TBL_LOW, `FSPS_OFS_TBL_HIGH: begin
          // RQ21 no table writes to configuration space
          lat_we = !cfg_sp;
          // the erase target comes from the last table write
          s_d.tgt = acc_adr;
          if (adr_i == `FSPS_OFS_TBL_LOW) begin
            // RQ2 word or single byte of low word
            if (word_mode) begin
              lat_mask = 24'h00ffff;
            end else if (s_q.ea[0]) begin
              lat_mask = 24'h00ff00;
              lat_dat  = {8'h00, dat_i[7:0], 8'h00};
            end else begin
              lat_mask = 24'h0000ff;
            end
          end else begin
            // RQ3 high byte; phantom byte write dropped
            lat_mask = (word_mode || !s_q.ea[0]) ? 24'hff0000 : 24'h000000;
            lat_dat  = {dat_i[7:0], 16'h0000};
          end
        end
        default: s_d.key = fsps_pkg::FSPS_KEY_NONE;
      endcase
    end
    // sequencer phases
    case (s_q.ph)
      fsps_pkg::FSPS_IDLE: s_d.tmr = '0;
      // one array word per cycle
      fsps_pkg::FSPS_RUN: begin
        mem_we = 1'b1;
        case (s_q.kind)
          // RQ5 single word from its latch
          fsps_pkg::FSPS_K_WORD: begin
            mem_idx = run_idx;
            mem_dat = lat_q[run_idx[5:0]];
          end
          // RQ4 RQ8 whole row from latches
          fsps_pkg::FSPS_K_ROW: begin
            mem_idx = {run_idx[AW-1:6], s_q.cnt[5:0]};
            mem_dat = lat_q[s_q.cnt[5:0]];
          end
          // RQ5 RQ6 eight-row aligned block
          fsps_pkg::FSPS_K_BLOCK: begin
            mem_idx = (run_idx & ~AW'(`FSPS_BLOCK_WORDS - 1)) | AW'(s_q.cnt[8:0]);
          end
          default: mem_idx = s_q.cnt[AW-1:0];
        endcase
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == s_q.last) s_d.ph = fsps_pkg::FSPS_SETTLE;
      end
      // self-timed wait before completion
      fsps_pkg::FSPS_SETTLE: begin
        s_d.tmr = s_q.tmr + 1'b1;
        if (s_q.tmr == 8'(`FSPS_OP_CYC - 1)) begin
          // RQ14 RQ16 hardware clears start, no error
          s_d.ph      = fsps_pkg::FSPS_IDLE;
          s_d.ctrl.wr = 1'b0;
          s_d.ctrl.err = 1'b0;
        end
      end
      default: s_d.ph = fsps_pkg::FSPS_IDLE;
    endcase
    // RQ16 RQ20 warm reset terminates, clears start, sets error if busy, keeps other control bits
    if (warm_rst) begin
      mem_we      = 1'b0;
      s_d.key     = fsps_pkg::FSPS_KEY_NONE;
      s_d.ph      = fsps_pkg::FSPS_IDLE;
      s_d.ctrl.wr = 1'b0;
      if (s_q.ph != fsps_pkg::FSPS_IDLE) s_d.ctrl.err = 1'b1;
    end
  end

  localparam logic [15:0] CTRL_RST = `FSPS_CTRL_RESET;  // register-wide reset value
  // RQ20 control bits cleared only by power-on reset
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q      <= '0;
      s_q.ctrl <= {CTRL_RST[15:13], CTRL_RST[6], CTRL_RST[3:0]};
    end else begin
      s_q <= s_d;
    end
  end

  // RQ10 latches take any order, last write wins
  always_ff @(posedge clk) begin
    if (lat_we) begin
      lat_q[lat_idx] <= (lat_q[lat_idx] & ~lat_mask) | (lat_dat & lat_mask);
    end
  end

  // RQ7 array changes only while sequencing
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[mem_idx] <= mem_dat;
    end
  end

  // outputs
  assign dat_o = s_q.dat;
  assign ack_o = s_q.ack;
  // RQ13 stall while operation runs
  assign stall = s_q.ph != fsps_pkg::FSPS_IDLE;

  // assertion bounds
  localparam int SETTLE_MAX = 300;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // a valid start of a word program
  sequence seq_word_start;
    start_ok && sel_word && !warm_rst;
  endsequence

  // a row program start
  sequence seq_row_start;
    start_ok && sel_row && !warm_rst;
  endsequence

  AST_BAD_START_ERR: assert property ( // RQ22
    (start_try && !start_ok && !warm_rst) |=> (s_q.ctrl.err && !stall)
  ) else $error("improper start did not flag error");

  AST_NO_ENABLE_NO_RUN: assert property ( // RQ15
    (start_try && !dat_i[`FSPS_BIT_WRITE_ENABLE_BIT]) |=> !s_q.ctrl.wr
  ) else $error("start ran with writes disabled");

  AST_STALL_NO_ACK: assert property ( // RQ13
    (stall && !$past(req)) |-> !ack_o
  ) else $error("bus answered during an operation");

  AST_WR_CLEARS_AT_END: assert property ( // RQ14
    $fell(s_q.ctrl.wr) |-> !stall
  ) else $error("start bit fell while still busy");

  AST_ARM_NEEDS_KEYS: assert property ( // RQ12
    $rose(s_q.key == fsps_pkg::FSPS_KEY_ARMED) |->
      $past(s_q.key) == fsps_pkg::FSPS_KEY_HALF && $past(dat_i[7:0]) == `FSPS_KEY_SECOND
  ) else $error("armed without 55h then AAh");

  AST_CFG_NO_WRITE: assert property ( // RQ21
    cfg_sp |-> !lat_we
  ) else $error("table write reached configuration space");

  AST_CTRL_ZERO_BITS: assert property ( // RQ23
    $past(rd_req && adr_i == `FSPS_OFS_CTRL) |->
      dat_o[12:7] == 6'h00 && dat_o[5:4] == 2'h0 && dat_o[31:16] == 16'h0000
  ) else $error("unimplemented control bits read nonzero");

  AST_ROW_SPAN: assert property ( // RQ4
    disable iff (srst || warm_rst) seq_row_start |=> (s_q.ph == fsps_pkg::FSPS_RUN)[*8]
      ##57 s_q.ph == fsps_pkg::FSPS_SETTLE
  ) else $error("row program did not span 64 words");

  AST_WORD_DONE: assert property ( // RQ5
    seq_word_start |=> stall ##[1:SETTLE_MAX] (!stall && !s_q.ctrl.err)
  ) else $error("word program did not complete cleanly");

  AST_ARRAY_ONLY_RUN: assert property ( // RQ7
    mem_we |-> s_q.ph == fsps_pkg::FSPS_RUN
  ) else $error("array written outside an operation");

endmodule // fsps_top

// ### tb/fsps_cpu_model.sv
// cpu side of the sequencer: classic wishbone master with register tasks
// assumes one free running clk shared with the slave, which acks every request
`timescale 1ns/1ns
`include "fsps_regs.svh"

module fsps_cpu_model (
  // clock
  input  wire logic        clk,
  // wishbone master outputs
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  // slave answer
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  // idle bus from time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // one cycle; on release we, address and data go inverted so stale values never look valid, sel is kept
  task automatic bus_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    @(posedge clk);
    // no fixed latency: stall may hold the answer back
    while (ack_i !== 1'b1) @(posedge clk);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= ~w;
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk);
  endtask

  // write with byte lanes
  task automatic wb_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] unused;
    bus_cycle(1'b1, a, d, s, unused);
  endtask

  // word read
  task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
    bus_cycle(1'b0, a, 32'h0000_0000, 4'h3, q);
  endtask

  task automatic unlock();
    wb_write(`FSPS_OFS_KEY, {24'h000000, `FSPS_KEY_FIRST}, 4'h3);
    wb_write(`FSPS_OFS_KEY, {24'h000000, `FSPS_KEY_SECOND}, 4'h3);
  endtask

  // every latch of a row set to ones
  task automatic fill_row(input logic [15:0] ea_base);
    for (int i = 0; i < `FSPS_ROW_WORDS; i++) begin
      wb_write(`FSPS_OFS_EA, {16'h0000, ea_base + 16'(2 * i)}, 4'h3);
      wb_write(`FSPS_OFS_TBL_LOW, 32'h0000_ffff, 4'h3);
      wb_write(`FSPS_OFS_TBL_HIGH, 32'h0000_00ff, 4'h3);
    end
  endtask
endmodule // fsps_cpu_model

// ### tb/fsps_tb_top.sv
// self-checking bench for the flash self-program sequencer
// assumes fsps_top driven by fsps_cpu_model on one 125 MHz clock
`timescale 1ns/1ns
`include "fsps_regs.svh"

`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end \
end

module fsps_tb_top;
  localparam int ARRAY_WORDS = 512;  // one erase block keeps bulk erase short
  localparam int SETTLE      = 250;  // self-timed settle cycles
  // start values that must be refused
  localparam logic [15:0] bad_codes [7] = '{16'h4043, 16'h4002, 16'h404f, 16'h4005,
                                            16'h4041, 16'h400f, 16'h0001};
  logic        clk, srst, warm_rst, ext_prog_mode, stall, ack, cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          mismatches, samples_checked;  // report counters
  int          stall_runs, stall_len, cur_len, runs0;
  logic        in_op;  // stall seen high last edge

  fsps_top #(.ARRAY_WORDS(ARRAY_WORDS)) dut (
    .clk(clk), .srst(srst), .warm_rst(warm_rst), .ext_prog_mode(ext_prog_mode),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .stall(stall));
  fsps_cpu_model cpu (
    .clk(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

  // 8 ns clock
  always #4 clk = ~clk;

  // measure each stall span, so op lengths are checked exactly
  always @(posedge clk) begin
    if (stall === 1'b1) begin
      if (!in_op) stall_runs++;
      cur_len = in_op ? cur_len + 1 : 1;
      in_op = 1'b1;
    end else begin
      if (in_op) stall_len = cur_len;
      in_op = 1'b0;
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    cpu.wb_read(a, q);
    `CHK(nm, exp, q) // read compare
  endtask

  // table pointer: page then effective address
  task automatic set_ptr(input logic [7:0] pg, input logic [15:0] ea);
    cpu.wb_write(`FSPS_OFS_PAGE, {24'h000000, pg}, 4'h3);
    cpu.wb_write(`FSPS_OFS_EA, {16'h0000, ea}, 4'h3);
  endtask

  // the read right after start is held off until the stall ends
  task automatic run_op(input logic [15:0] v, input int cycles, input string nm);
    logic [31:0] q;
    cpu.wb_write(`FSPS_OFS_CTRL, {16'h0000, v}, 4'h3);
    cpu.unlock();
    cpu.wb_write(`FSPS_OFS_CTRL, {16'h0000, v | 16'h8000}, 4'h3);
    cpu.wb_read(`FSPS_OFS_CTRL, q);
    `CHK(nm, 32'(cycles), 32'(stall_len)) // stall span
    `CHK("ctrl after op", {16'h0000, v}, q) // start clears
  endtask

  // mode 0 proper keys, 1 reversed, 2 interrupted, 3 none
  task automatic bad_start(input logic [15:0] v, input int mode);
    cpu.wb_write(`FSPS_OFS_CTRL, {16'h0000, v}, 4'h3);
    if (mode == 0) begin
      cpu.unlock();
    end else if (mode == 1) begin
      cpu.wb_write(`FSPS_OFS_KEY, 32'h0000_00aa, 4'h3);
      cpu.wb_write(`FSPS_OFS_KEY, 32'h0000_0055, 4'h3);
    end else if (mode == 2) begin
      cpu.wb_write(`FSPS_OFS_KEY, 32'h0000_0055, 4'h3);
      cpu.wb_write(`FSPS_OFS_PAGE, 32'h0000_0000, 4'h3);
      cpu.wb_write(`FSPS_OFS_KEY, 32'h0000_00aa, 4'h3);
    end
    cpu.wb_write(`FSPS_OFS_CTRL, {16'h0000, v | 16'h8000}, 4'h3);
    expect_rd(`FSPS_OFS_CTRL, {16'h0000, v | 16'h2000}, "bad start");
  endtask

  // watchdog well beyond the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    warm_rst = 1'b0;
    ext_prog_mode = 1'b0;
    in_op = 1'b0;
    stall_runs = 0;
    stall_len = 0;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    expect_rd(`FSPS_OFS_CTRL, 32'h0000_0000, "ctrl reset");
    cpu.wb_write(`FSPS_OFS_CTRL, 32'hffff_7fff, 4'h3);
    expect_rd(`FSPS_OFS_CTRL, 32'h0000_604f, "ctrl mask");
    expect_rd(`FSPS_OFS_KEY, 32'h0000_0000, "key read");
    expect_rd(8'h40, 32'h0000_0000, "unmapped");
    // block erase targeted by a dummy latch write
    set_ptr(8'h00, 16'h0000);
    cpu.wb_write(`FSPS_OFS_TBL_LOW, 32'h0000_0000, 4'h3);
    run_op(16'h4042, `FSPS_BLOCK_WORDS + SETTLE, "erase stall");
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_ffff, "erased low");
    set_ptr(8'h80, 16'h0000);
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_0000, "config read");
    set_ptr(8'h00, 16'h03fe);
    expect_rd(`FSPS_OFS_TBL_HIGH, 32'h0000_00ff, "erased high");
    // row at word 64, one latch rewritten, target not row aligned
    cpu.fill_row(16'h0080);
    set_ptr(8'h00, 16'h0086);
    cpu.wb_write(`FSPS_OFS_TBL_LOW, 32'h0000_1111, 4'h3);
    cpu.wb_write(`FSPS_OFS_TBL_LOW, 32'h0000_1234, 4'h3);
    cpu.wb_write(`FSPS_OFS_TBL_HIGH, 32'h0000_0056, 4'h3);
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_ffff, "latch not array");
    run_op(16'h4001, `FSPS_ROW_WORDS + SETTLE, "row stall");
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_1234, "row low");
    expect_rd(`FSPS_OFS_TBL_HIGH, 32'h0000_0056, "row high");
    set_ptr(8'h00, 16'h0080);
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_ffff, "row start");
    // word program loaded by byte writes
    set_ptr(8'h00, 16'h0101);
    cpu.wb_write(`FSPS_OFS_TBL_LOW, 32'h0000_00cd, 4'h1);
    set_ptr(8'h00, 16'h0100);
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_ffff, "next row untouched");
    cpu.wb_write(`FSPS_OFS_TBL_LOW, 32'h0000_00ab, 4'h1);
    cpu.wb_write(`FSPS_OFS_TBL_HIGH, 32'h0000_0077, 4'h3);
    run_op(16'h4003, 1 + SETTLE, "word stall");
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_cdab, "word low");
    expect_rd(`FSPS_OFS_TBL_HIGH, 32'h0000_0077, "word high");
    set_ptr(8'h00, 16'h0102);
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_ffff, "word only");
    // refused starts never stall the cpu
    runs0 = stall_runs;
    for (int i = 0; i < 7; i++) bad_start(bad_codes[i], 0);
    for (int m = 1; m < 4; m++) bad_start(16'h4001, m);
    `CHK("no op started", 32'(runs0), 32'(stall_runs)) // refused
    // warm reset aborts a row program, keeps the other bits
    cpu.wb_write(`FSPS_OFS_CTRL, 32'h0000_4001, 4'h3);
    cpu.unlock();
    cpu.wb_write(`FSPS_OFS_CTRL, 32'h0000_c001, 4'h3);
    repeat (20) @(posedge clk);
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    expect_rd(`FSPS_OFS_CTRL, 32'h0000_6001, "warm abort");
    `CHK("stall after abort", 1'b0, stall) // released
    // bulk erase only with the serial mode pin up
    ext_prog_mode <= 1'b1;
    run_op(16'h404f, ARRAY_WORDS + SETTLE, "bulk stall");
    set_ptr(8'h00, 16'h0100);
    expect_rd(`FSPS_OFS_TBL_LOW, 32'h0000_ffff, "bulk erased");
    // power-on reset clears the control bits
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    expect_rd(`FSPS_OFS_CTRL, 32'h0000_0000, "por clears");
    end_sim();
  end
endmodule // fsps_tb_top
